/* File: verilog/wdtc_pkg.sv */
// constants and types for the watchdog timer control block
package wdtc_pkg;

    // ------------------------------------------------------------
    // special function register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] SFR_CLOCK_CONTROL = 8'h8E;
    localparam logic [7:0] SFR_ACCESS_UNLOCK = 8'hC7;
    localparam logic [7:0] SFR_WDT_CONTROL = 8'hD8;
    localparam logic [7:0] SFR_EXT_IRQ_ENABLE = 8'hE8;
    localparam logic [7:0] SFR_EXT_IRQ_PRIORITY = 8'hF8;

    // ------------------------------------------------------------
    // reset values and unlock keys
    // ------------------------------------------------------------
    localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h03;
    localparam logic [7:0] WDT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'hAA;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h55;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CK_INTERVAL_LSB = 6;
    localparam int CK_MODE_MSB = 2;
    localparam int WDC_RESTART_BIT = 0;
    localparam int WDC_RESET_EN_BIT = 1;
    localparam int WDC_CAUSE_BIT = 2;
    localparam int WDC_TIMEOUT_BIT = 3;
    localparam int EXT_WDT_BIT = 4;

    // ------------------------------------------------------------
    // timing, in clk_sys cycles, and interrupt identity
    // ------------------------------------------------------------
    localparam int unsigned INTERVAL_CODE_00 = 32'h0002_0000;
    localparam int unsigned INTERVAL_CODE_01 = 32'h0010_0000;
    localparam int unsigned INTERVAL_CODE_10 = 32'h0080_0000;
    localparam int unsigned INTERVAL_CODE_11 = 32'h0400_0000;
    localparam int unsigned RESET_DELAY_CLKS = 32'h0000_0200;
    localparam int DELAY_W = 10;
    localparam logic [7:0] WDT_IRQ_VECTOR = 8'h63;
    localparam logic [3:0] WDT_IRQ_NAT_PRIO = 4'hB;

    // unlock sequence state
    typedef enum logic [1:0] {
        UL_IDLE = 2'b00,
        UL_GOT_FIRST = 2'b01,
        UL_OPEN = 2'b10
    } wdtc_unlock_type;

endpackage

/* File: verilog/wdtc_watchdog.sv */
// watchdog timer with a timed-access watchdog control register on the sfr port
`timescale 1ns/1ps

module wdtc_watchdog #(
    parameter int unsigned INTERVAL_00 = wdtc_pkg::INTERVAL_CODE_00,
    parameter int unsigned INTERVAL_01 = wdtc_pkg::INTERVAL_CODE_01,
    parameter int unsigned INTERVAL_10 = wdtc_pkg::INTERVAL_CODE_10,
    parameter int unsigned INTERVAL_11 = wdtc_pkg::INTERVAL_CODE_11,
    parameter int CNT_W = 27
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic sys_reset_req,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic global_irq_enable,
    output logic wdt_irq_req,
    output logic wdt_irq_priority,
    output logic [7:0] wdt_irq_vector,
    output logic [3:0] wdt_irq_nat_prio,
    output logic wdt_reset_pulse
);
    import wdtc_pkg::*;

    // ------------------------------------------------------------
    // interval decode
    // ------------------------------------------------------------

    // last count value before timeout for a select code
    function automatic logic [CNT_W-1:0] interval_last(input logic [1:0] sel);
        int unsigned n;
        n = INTERVAL_00;
        if (sel == 2'b01) begin
            n = INTERVAL_01;
        end else if (sel == 2'b10) begin
            n = INTERVAL_10;
        end else if (sel == 2'b11) begin
            n = INTERVAL_11;
        end
        return CNT_W'(n - 1);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    wdtc_unlock_type unlock_q, unlock_d;
    logic [1:0] interval_select_q, interval_select_d;
    logic [2:0] ck_mode_q, ck_mode_d;
    logic reset_enable_q, reset_enable_d;
    logic reset_cause_flag_q, reset_cause_flag_d;
    logic timeout_flag_q, timeout_flag_d;
    logic count_restart_q, count_restart_d;
    logic wdt_irq_enable_q, wdt_irq_enable_d;
    logic wdt_irq_priority_q, wdt_irq_priority_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic pending_q, pending_d;
    logic [DELAY_W-1:0] dly_q, dly_d;
    logic reset_q, reset_d;
    logic [7:0] rdata_q, rdata_d;
    logic timeout_ev;
    logic fire;
    logic watchdog_control_wr;
    logic watchdog_control_wr_ok;

    // ------------------------------------------------------------
    // timer: counter, delay window and reset strobe
    // ------------------------------------------------------------

    // timeout when the free-running count reaches the selected limit
    assign timeout_ev = (cnt_q == interval_last(interval_select_q));
    // reset fires only with reset enable set at the end of the window
    assign fire = pending_q && (dly_q == DELAY_W'(RESET_DELAY_CLKS - 1))
        && reset_enable_q && !count_restart_q;

    // next timer values
    always_comb begin
        cnt_d = cnt_q + CNT_W'(1);
        pending_d = pending_q;
        dly_d = dly_q;
        reset_d = 1'b0;
        if (pending_q) begin
            dly_d = dly_q + DELAY_W'(1);
            if (dly_q == DELAY_W'(RESET_DELAY_CLKS - 1)) begin
                pending_d = 1'b0; // window over, reset or not
            end
        end
        if (timeout_ev) begin
            cnt_d = '0;
            pending_d = 1'b1;
            dly_d = '0; // strobe lands 512 cycles after the flag sets
        end
        if (fire) begin
            reset_d = 1'b1;
            cnt_d = '0;
        end
        if (count_restart_q) begin
            cnt_d = '0;
            pending_d = 1'b0;
            dly_d = '0;
        end
        if (sys_reset_req) begin
            cnt_d = '0;
            pending_d = 1'b0;
            dly_d = '0;
            reset_d = 1'b0;
        end
    end

    // timer registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            pending_q <= 1'b0;
            dly_q <= '0;
            reset_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pending_q <= pending_d;
            dly_q <= dly_d;
            reset_q <= reset_d;
        end
    end

    // ------------------------------------------------------------
    // sfr writes, timed access and control bits
    // ------------------------------------------------------------

    assign watchdog_control_wr = sfr_wr && (sfr_addr == SFR_WDT_CONTROL);
    assign watchdog_control_wr_ok = watchdog_control_wr && (unlock_q == UL_OPEN);

    // next register values; hardware sets win over software clears
    always_comb begin
        unlock_d = unlock_q;
        interval_select_d = interval_select_q;
        ck_mode_d = ck_mode_q;
        reset_enable_d = reset_enable_q;
        reset_cause_flag_d = reset_cause_flag_q;
        timeout_flag_d = timeout_flag_q;
        count_restart_d = 1'b0;
        wdt_irq_enable_d = wdt_irq_enable_q;
        wdt_irq_priority_d = wdt_irq_priority_q;
        if (sfr_wr) begin
            // any write other than the next key drops the unlock
            unlock_d = UL_IDLE;
            if (sfr_addr == SFR_ACCESS_UNLOCK) begin
                if (sfr_wdata == UNLOCK_KEY_FIRST) begin
                    unlock_d = UL_GOT_FIRST;
                end else if (unlock_q == UL_GOT_FIRST && sfr_wdata == UNLOCK_KEY_SECOND) begin
                    unlock_d = UL_OPEN;
                end
            end else if (sfr_addr == SFR_CLOCK_CONTROL) begin
                interval_select_d = sfr_wdata[CK_INTERVAL_LSB +: 2];
                ck_mode_d = sfr_wdata[CK_MODE_MSB:0];
            end else if (sfr_addr == SFR_EXT_IRQ_ENABLE) begin
                wdt_irq_enable_d = sfr_wdata[EXT_WDT_BIT];
            end else if (sfr_addr == SFR_EXT_IRQ_PRIORITY) begin
                wdt_irq_priority_d = sfr_wdata[EXT_WDT_BIT];
            end
        end
        if (watchdog_control_wr_ok) begin
            count_restart_d = sfr_wdata[WDC_RESTART_BIT];
            reset_enable_d = sfr_wdata[WDC_RESET_EN_BIT];
            // software may set the cause flag; no reset follows
            reset_cause_flag_d = sfr_wdata[WDC_CAUSE_BIT];
            timeout_flag_d = sfr_wdata[WDC_TIMEOUT_BIT];
        end
        // flag is set regardless of reset enable
        if (timeout_ev) begin
            timeout_flag_d = 1'b1;
        end
        if (fire) begin
            reset_cause_flag_d = 1'b1;
            timeout_flag_d = 1'b0;
            interval_select_d = CLOCK_CONTROL_RESET[CK_INTERVAL_LSB +: 2];
            ck_mode_d = CLOCK_CONTROL_RESET[CK_MODE_MSB:0];
            wdt_irq_enable_d = 1'b0;
            wdt_irq_priority_d = 1'b0;
            unlock_d = UL_IDLE;
        end
        // reset from elsewhere clears everything, cause flag included
        if (sys_reset_req) begin
            unlock_d = UL_IDLE;
            interval_select_d = CLOCK_CONTROL_RESET[CK_INTERVAL_LSB +: 2];
            ck_mode_d = CLOCK_CONTROL_RESET[CK_MODE_MSB:0];
            reset_enable_d = WDT_CONTROL_RESET[WDC_RESET_EN_BIT];
            reset_cause_flag_d = WDT_CONTROL_RESET[WDC_CAUSE_BIT];
            timeout_flag_d = WDT_CONTROL_RESET[WDC_TIMEOUT_BIT];
            count_restart_d = 1'b0;
            wdt_irq_enable_d = 1'b0;
            wdt_irq_priority_d = 1'b0;
        end
    end

    // control registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            unlock_q <= UL_IDLE;
            interval_select_q <= CLOCK_CONTROL_RESET[CK_INTERVAL_LSB +: 2];
            ck_mode_q <= CLOCK_CONTROL_RESET[CK_MODE_MSB:0];
            reset_enable_q <= WDT_CONTROL_RESET[WDC_RESET_EN_BIT];
            reset_cause_flag_q <= WDT_CONTROL_RESET[WDC_CAUSE_BIT];
            timeout_flag_q <= WDT_CONTROL_RESET[WDC_TIMEOUT_BIT];
            count_restart_q <= 1'b0;
            wdt_irq_enable_q <= 1'b0;
            wdt_irq_priority_q <= 1'b0;
        end else begin
            unlock_q <= unlock_d;
            interval_select_q <= interval_select_d;
            ck_mode_q <= ck_mode_d;
            reset_enable_q <= reset_enable_d;
            reset_cause_flag_q <= reset_cause_flag_d;
            timeout_flag_q <= timeout_flag_d;
            count_restart_q <= count_restart_d;
            wdt_irq_enable_q <= wdt_irq_enable_d;
            wdt_irq_priority_q <= wdt_irq_priority_d;
        end
    end

    // ------------------------------------------------------------
    // read data and outputs
    // ------------------------------------------------------------

    // read mux; restart bit always reads back zero
    always_comb begin
        rdata_d = rdata_q;
        if (sfr_rd) begin
            rdata_d = 8'h00;
            if (sfr_addr == SFR_CLOCK_CONTROL) begin
                rdata_d[CK_INTERVAL_LSB +: 2] = interval_select_q;
                rdata_d[CK_MODE_MSB:0] = ck_mode_q;
            end else if (sfr_addr == SFR_WDT_CONTROL) begin
                rdata_d[WDC_RESET_EN_BIT] = reset_enable_q;
                rdata_d[WDC_CAUSE_BIT] = reset_cause_flag_q;
                rdata_d[WDC_TIMEOUT_BIT] = timeout_flag_q;
            end else if (sfr_addr == SFR_EXT_IRQ_ENABLE) begin
                rdata_d[EXT_WDT_BIT] = wdt_irq_enable_q;
            end else if (sfr_addr == SFR_EXT_IRQ_PRIORITY) begin
                rdata_d[EXT_WDT_BIT] = wdt_irq_priority_q;
            end
        end
    end

    // read data register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // request follows the flag at once, so a software set works too
    assign wdt_irq_req = timeout_flag_q && wdt_irq_enable_q && global_irq_enable;
    assign wdt_irq_priority = wdt_irq_priority_q;
    assign wdt_irq_vector = WDT_IRQ_VECTOR;
    assign wdt_irq_nat_prio = WDT_IRQ_NAT_PRIO;
    assign wdt_reset_pulse = reset_q;
    assign sfr_rdata = rdata_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_irq_gate: assert property (
        (timeout_flag_q && wdt_irq_enable_q && global_irq_enable) |-> wdt_irq_req
        ) else $error("flag with enables raised no request");
    a_irq_needs_en: assert property (
        !wdt_irq_enable_q |-> !wdt_irq_req
        ) else $error("request without enable");
    a_reset_delay: assert property (
        wdt_reset_pulse |-> $past(timeout_ev, 513)
        ) else $error("reset not 512 cycles after timeout");
    a_no_reset_dis: assert property (
        (pending_q && !reset_enable_q) |=> !wdt_reset_pulse
        ) else $error("reset while reset enable clear");
    a_cause_set: assert property (
        (wdt_reset_pulse && !$past(sys_reset_req)) |-> reset_cause_flag_q
        ) else $error("cause flag missing after reset");
    a_cause_stable: assert property (
        (!fire && !watchdog_control_wr_ok && !sys_reset_req) |=> $stable(reset_cause_flag_q)
        ) else $error("cause flag changed without cause");
    a_locked_write: assert property (
        (watchdog_control_wr && unlock_q != UL_OPEN && !fire && !sys_reset_req)
        |=> $stable(reset_enable_q) && !count_restart_q
        ) else $error("locked control write took effect");
    a_unlock_once: assert property (
        watchdog_control_wr_ok |=> unlock_q == UL_IDLE
        ) else $error("unlock survived its write");
    a_restart_clear: assert property (
        (count_restart_q && !sys_reset_req) |=> cnt_q == '0 && !pending_q ##1 cnt_q == CNT_W'(1)
        ) else $error("restart did not clear count");
    a_restart_strobe: assert property (
        count_restart_q |=> !count_restart_q
        ) else $error("restart bit stuck");
    a_runs_on: assert property (
        (wdt_reset_pulse && !sys_reset_req && !count_restart_q) |=> cnt_q == CNT_W'(1)
        ) else $error("counter stopped after watchdog reset");
    a_flag_set: assert property (
        (timeout_ev && !sys_reset_req) |=> timeout_flag_q
        ) else $error("timeout did not set flag");
    a_sys_clear: assert property (
        sys_reset_req |=> cnt_q == '0 && interval_select_q == 2'b00
        ) else $error("system reset left count or select");

    c_timeout: cover property (timeout_ev);
    c_wdt_reset: cover property (wdt_reset_pulse);
    c_restart_saves: cover property (pending_q && count_restart_q);
    c_irq: cover property (wdt_irq_req);

endmodule

/* File: verif/wdtc_watchdog_tb_top.sv */
// self-checking testbench for the watchdog timer control block
`timescale 1ns/1ps

module wdtc_watchdog_tb_top;
    import wdtc_pkg::*;

    // ----------------------------------------
    // signals and bookkeeping
    // ----------------------------------------
    logic clk_sys;
    logic arst_n;
    logic sys_reset_req;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic [7:0] sfr_wdata;
    logic sfr_rd;
    logic [7:0] sfr_rdata;
    logic global_irq_enable;
    logic wdt_irq_req;
    logic wdt_irq_priority;
    logic [7:0] wdt_irq_vector;
    logic [3:0] wdt_irq_nat_prio;
    logic wdt_reset_pulse;
    logic irq_prev = 1'b0;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int last_rise = 0;
    int last_pulse = 0;
    int pulse_cnt = 0;
    // short intervals keep the run small; all exceed the 512 delay window
    localparam int IV [4] = '{600, 700, 800, 900};

    wdtc_watchdog #(.INTERVAL_00(IV[0]), .INTERVAL_01(IV[1]), .INTERVAL_10(IV[2]),
        .INTERVAL_11(IV[3]), .CNT_W(27)) wdtc_watchdog_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .sys_reset_req(sys_reset_req),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .global_irq_enable(global_irq_enable),
        .wdt_irq_req(wdt_irq_req), .wdt_irq_priority(wdt_irq_priority),
        .wdt_irq_vector(wdt_irq_vector), .wdt_irq_nat_prio(wdt_irq_nat_prio),
        .wdt_reset_pulse(wdt_reset_pulse));

    // 50 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // event monitor: edge times of irq and reset pulse
    // ----------------------------------------
    // both sampled before the edge's own updates, so differences stay exact
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        irq_prev <= wdt_irq_req;
        if (wdt_irq_req === 1'b1 && irq_prev !== 1'b1) last_rise <= cyc;
        if (wdt_reset_pulse === 1'b1) begin
            pulse_cnt <= pulse_cnt + 1;
            last_pulse <= cyc;
        end
    end

    // ----------------------------------------
    // bus tasks and comparisons
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask

    // unlock keys then the guarded write, nothing in between
    task automatic twr(input logic [7:0] d);
        wr(SFR_ACCESS_UNLOCK, UNLOCK_KEY_FIRST);
        wr(SFR_ACCESS_UNLOCK, UNLOCK_KEY_SECOND);
        wr(SFR_WDT_CONTROL, d);
    endtask

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_cyc(input int g, input int e);
        checks++;
        if (g != e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // read data is registered, so it is taken just after the read edge
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1 chk_byte(sfr_rdata, e);
    endtask

    // bounded waits; a missing event counts as a mismatch
    task automatic wait_rise(output int t);
        int old;
        int i;
        old = last_rise;
        for (i = 0; i < 2000 && last_rise == old; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk_cyc(last_rise == old ? 0 : 1, 1);
        t = last_rise;
    endtask

    task automatic quiet(input int n, input int pulses);
        repeat (n) @(posedge clk_sys);
        #1 chk_cyc(pulse_cnt, pulses);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog on the bench itself: tests need about 9000 cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        complete_run();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        int r1;
        int r2;
        int p;
        arst_n = 1'b0;
        sys_reset_req = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        sfr_rd = 1'b0;
        global_irq_enable = 1'b1;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        // reset values, unmapped and write-only places
        chk_rd(SFR_CLOCK_CONTROL, 8'h03);
        chk_rd(SFR_WDT_CONTROL, 8'h00);
        chk_rd(SFR_ACCESS_UNLOCK, 8'h00);
        chk_rd(8'h12, 8'h00);
        chk_byte(wdt_irq_vector, 8'h63);
        chk_byte({4'h0, wdt_irq_nat_prio}, 8'h0B);
        $display("test reset_values done");
        // guarded writes without a clean unlock are dropped
        wr(SFR_WDT_CONTROL, 8'h02);
        chk_rd(SFR_WDT_CONTROL, 8'h00);
        wr(SFR_ACCESS_UNLOCK, UNLOCK_KEY_FIRST);
        wr(SFR_CLOCK_CONTROL, 8'h03);
        wr(SFR_ACCESS_UNLOCK, UNLOCK_KEY_SECOND);
        wr(SFR_WDT_CONTROL, 8'h02);
        chk_rd(SFR_WDT_CONTROL, 8'h00);
        twr(8'h00);
        wr(SFR_WDT_CONTROL, 8'h02);
        chk_rd(SFR_WDT_CONTROL, 8'h00);
        $display("test unlock_refusal done");
        // enable and priority live at bit 4 only
        wr(SFR_EXT_IRQ_ENABLE, 8'hFF);
        chk_rd(SFR_EXT_IRQ_ENABLE, 8'h10);
        wr(SFR_EXT_IRQ_PRIORITY, 8'h10);
        chk_rd(SFR_EXT_IRQ_PRIORITY, 8'h10);
        chk_byte({7'h00, wdt_irq_priority}, 8'h01);
        wr(SFR_EXT_IRQ_PRIORITY, 8'hEF);
        chk_rd(SFR_EXT_IRQ_PRIORITY, 8'h00);
        chk_byte({7'h00, wdt_irq_priority}, 8'h00);
        $display("test irq_bits done");
        // each interval code, measured between two successive timeouts
        for (int c = 0; c < 4; c++) begin
            // mode bits change too; the count must not follow them
            wr(SFR_CLOCK_CONTROL, {c[1:0], 3'h0, c[2:0]});
            twr(8'h01);
            chk_rd(SFR_CLOCK_CONTROL, {c[1:0], 3'h0, c[2:0]});
            wait_rise(r1);
            twr(8'h00);
            wait_rise(r2);
            chk_cyc(r2 - r1, IV[c]);
        end
        $display("test intervals done");
        // reset enabled: pulse follows timeout, cause flag set, timer keeps running
        wr(SFR_CLOCK_CONTROL, 8'h03);
        twr(8'h03);
        chk_rd(SFR_WDT_CONTROL, 8'h02);
        wait_rise(r1);
        p = pulse_cnt;
        quiet(520, p + 1);
        chk_cyc(last_pulse - r1, int'(RESET_DELAY_CLKS));
        chk_rd(SFR_WDT_CONTROL, 8'h06);
        chk_rd(SFR_EXT_IRQ_ENABLE, 8'h00);
        wr(SFR_EXT_IRQ_ENABLE, 8'h10);
        wait_rise(r2);
        chk_cyc(r2 - last_pulse, IV[0]);
        $display("test watchdog_reset done");
        // restart inside the window cancels the pending reset
        twr(8'h03);
        quiet(540, p + 1);
        // reset disabled: flag only, no pulse, cause flag untouched
        twr(8'h00);
        wait_rise(r1);
        quiet(540, p + 1);
        chk_rd(SFR_WDT_CONTROL, 8'h08);
        $display("test restart_and_disable done");
        // software-set cause flag triggers no reset
        twr(8'h04);
        quiet(20, p + 1);
        chk_rd(SFR_WDT_CONTROL, 8'h04);
        // software-set timeout flag raises the request, gated by global enable
        twr(8'h08);
        @(posedge clk_sys);
        #1 chk_byte({7'h00, wdt_irq_req}, 8'h01);
        @(posedge clk_sys);
        global_irq_enable <= 1'b0;
        #1 chk_byte({7'h00, wdt_irq_req}, 8'h00);
        wr(SFR_EXT_IRQ_ENABLE, 8'h00);
        global_irq_enable <= 1'b1;
        @(posedge clk_sys);
        #1 chk_byte({7'h00, wdt_irq_req}, 8'h00);
        $display("test software_flags done");
        // other reset source clears select, control and enables
        wr(SFR_CLOCK_CONTROL, 8'hC3);
        wr(SFR_EXT_IRQ_ENABLE, 8'h10);
        @(posedge clk_sys);
        sys_reset_req <= 1'b1;
        @(posedge clk_sys);
        sys_reset_req <= 1'b0;
        chk_rd(SFR_CLOCK_CONTROL, 8'h03);
        chk_rd(SFR_WDT_CONTROL, 8'h00);
        chk_rd(SFR_EXT_IRQ_ENABLE, 8'h00);
        $display("test system_reset done");
        complete_run();
    end

endmodule
